// File: hw/scs_pkg.sv
// What this block does
// R1: Bypass leaves line driving to firmware
// R2: Firmware handles convention, parity, error, checks
// R3: Sync card clock comes from divider
// R4: Firmware programs divider before sync transfers
// R5: Only selected interface runs sync clock
// R6: Sample on rise, change on fall
// R7: Sync enable: protocol bits 7 and 5
// R8: Clock stop and level work in sync
// R9: Stop waits for full current phase
// R10: Restart low: half low; high: drop now
// R11: Bit-length counter counts falling card edges
// R12: Zero length: no counting, line from controls
// R13: Reaching length sets maskable flag bit 7
// R14: Halted counter needs firmware reload
// R15: First fall after high restart skips FIFO; the code skips it only while the count is still zero
// R16: Rising edge captures line into bit 5
// R17: Direct-line mode: line follows control bits once count is reached
// R18: Nine-bit mode stores ninth bit, flags on capture
// R19: Drain receive; two transmit reads flush
// R20: Direction change resets bit pointer
// R21: Nine-bit and direct-line only in sync
// R22: Sync card reset follows firmware bit
// R23: Select field: 00 none, 01 external, 1X internal
// R24: Bypass bit hands line to control bits
// R25: Load clears count and reached state
package scs_pkg;
  localparam int unsigned PROTO_INT_SYNC_BIT = 7;
  localparam int unsigned PROTO_NINE_BIT_BIT = 6;
  localparam int unsigned PROTO_EXT_SYNC_BIT = 5;
  localparam int unsigned TXCTL_DIRECT_BIT   = 7;
  localparam int unsigned IRQ_BIT_LEN_BIT    = 7;
  localparam int unsigned BYTE_LAST_BIT      = 7;
  localparam int unsigned NINE_LAST_BIT      = 8;
  localparam logic [1:0]  SEL_EXTERNAL       = 2'h1;
  localparam logic [7:0]  LEN_DISABLED       = 8'h00;
  localparam logic [3:0]  PTR_FIRST          = 4'h0;
  localparam logic [3:0]  PTR_STEP           = 4'h1;
  localparam logic [7:0]  CNT_STEP           = 8'h01;
endpackage : scs_pkg

// File: hw/scs_sync.sv
`timescale 1ns/1ns
module scs_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_flush,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        ready;
  } scs_fifo_st_t;
  scs_fifo_st_t st_r, st_nxt;
  logic do_wr, do_rd;
  always_comb begin
    st_nxt = st_r;
    do_wr  = i_in_valid && st_r.ready;
    do_rd  = i_out_ready && (st_r.cnt != '0);
    if (do_wr) begin
      st_nxt.mem[st_r.wr] = i_in_data;
      st_nxt.wr = (st_r.wr == LAST_IDX) ? '0 : st_r.wr + 1'b1;
    end
    if (do_rd) begin
      st_nxt.rd = (st_r.rd == LAST_IDX) ? '0 : st_r.rd + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    if (i_flush) begin
      st_nxt.wr  = '0;
      st_nxt.rd  = '0;
      st_nxt.cnt = '0;
    end
    // Registered so the filling side sees a clean ready
    st_nxt.ready = (st_nxt.cnt != FULL_CNT);
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r <= '0;
      st_r.ready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_in_ready  = st_r.ready;
  assign o_out_data  = st_r.mem[st_r.rd];
  assign o_out_valid = (st_r.cnt != '0);
endmodule : scs_fifo

module scs_sync #(
  parameter int unsigned DIV_W = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             I_CLOCK,
  input  wire logic             I_SRST,
  input  wire logic [1:0]       I_INTERFACE_SELECT_FIELD,
  input  wire logic             I_BYPASS_ENABLE,
  input  wire logic [7:0]       I_PROTOCOL_CONFIG_REG,
  input  wire logic [7:0]       I_TRANSMIT_CONTROL_REG,
  input  wire logic [7:0]       I_CARD_IRQ_ENABLE_REG,
  input  wire logic [DIV_W-1:0] I_ETU_HALF_PERIOD,
  input  wire logic             I_INTERNAL_CLOCK_STOP,
  input  wire logic             I_INTERNAL_CLOCK_STOP_LEVEL,
  input  wire logic             I_EXTERNAL_CLOCK_STOP,
  input  wire logic             I_EXTERNAL_CLOCK_STOP_LEVEL,
  input  wire logic             I_INTERNAL_ASYNC_CLOCK,
  input  wire logic             I_EXTERNAL_ASYNC_CLOCK,
  input  wire logic             I_BIT_LENGTH_LOAD,
  input  wire logic [7:0]       I_BIT_LENGTH_VALUE,
  input  wire logic             I_IRQ_CLEAR,
  input  wire logic             I_TX_MODE,
  input  wire logic             I_INTERNAL_LINE_DATA,
  input  wire logic             I_INTERNAL_LINE_DIR,
  input  wire logic             I_EXTERNAL_LINE_DATA,
  input  wire logic             I_EXTERNAL_LINE_DIR,
  input  wire logic             I_CARD_RESET_BIT,
  input  wire logic             I_SEQUENCER_CARD_RESET,
  input  wire logic [7:0]       I_TX_DATA,
  input  wire logic             I_TX_VALID,
  output logic                  O_TX_READY,
  input  wire logic             I_TX_FIFO_READ,
  output logic [8:0]            O_RX_DATA,
  output logic                  O_RX_VALID,
  input  wire logic             I_RX_READY,
  input  wire logic             I_INTERNAL_IO,
  output logic                  O_INTERNAL_IO,
  output logic                  O_INTERNAL_IO_OE,
  input  wire logic             I_EXTERNAL_CARD_LINE,
  output logic                  O_EXTERNAL_CARD_LINE,
  output logic                  O_EXTERNAL_CARD_LINE_OE,
  output logic                  O_INTERNAL_CARD_CLOCK,
  output logic                  O_EXTERNAL_CARD_CLOCK,
  output logic                  O_CARD_RESET,
  output logic                  O_INTERNAL_LINE_SAMPLE,
  output logic                  O_EXTERNAL_LINE_SAMPLE,
  output logic                  O_BIT_LENGTH_IRQ_FLAG,
  output logic                  O_IRQ,
  output logic                  O_RECEIVE_DATA_AVAILABLE,
  output logic [7:0]            O_BIT_COUNT
);
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic             sclk;
    logic             stop_d;
    logic [7:0]       len;
    logic [7:0]       cnt;
    logic             done;
    logic             flag;
    logic [3:0]       ptr;
    logic             tx_mode_d;
    logic [8:0]       sh_rx;
    logic [7:0]       sh_tx;
    logic             tx_bit;
    logic             int_s1, int_s2, ext_s1, ext_s2;
    logic             int_clk, ext_clk, int_io, int_oe, ext_io, ext_oe;
    logic             int_samp, ext_samp, card_rst, irq, rx_dav;
    logic [8:0]       rx_out;
    logic             rx_vld;
    logic             rd_once;
  } scs_st_t;
  scs_st_t st_r, st_nxt;

  logic       tx_f_valid, tx_f_ready_out, tx_flush, rx_push, rx_f_ready, rx_f_valid, rx_pop;
  logic [7:0] tx_f_data;
  logic [8:0] rx_word, rx_f_data;

  scs_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
    .i_clk       (I_CLOCK),
    .i_srst      (I_SRST),
    .i_flush     (tx_flush),
    .i_in_data   (I_TX_DATA),
    .i_in_valid  (I_TX_VALID),
    .o_in_ready  (O_TX_READY),
    .o_out_data  (tx_f_data),
    .o_out_valid (tx_f_valid),
    .i_out_ready (tx_f_ready_out)
  );
  scs_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_rx_fifo (
    .i_clk       (I_CLOCK),
    .i_srst      (I_SRST),
    .i_flush     (1'b0),
    .i_in_data   (rx_word),
    .i_in_valid  (rx_push),
    .o_in_ready  (rx_f_ready),
    .o_out_data  (rx_f_data),
    .o_out_valid (rx_f_valid),
    .i_out_ready (rx_pop)
  );

  logic             sel_int, sel_ext, sync_on, stop, lvl, line_in, counting, halted;
  logic             rise, fall, skip, nine, direct, engine, set_flag;
  logic [DIV_W-1:0] half;
  logic [3:0]       last_ptr;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rx_dav = 1'b0;
    tx_f_ready_out = 1'b0;
    rx_push = 1'b0;
    rx_word = st_r.sh_rx;
    rise = 1'b0;
    fall = 1'b0;
    skip = 1'b0;
    set_flag = 1'b0;
    // Select decode
    // R23: select field decode
    sel_int = I_INTERFACE_SELECT_FIELD[1];
    sel_ext = (I_INTERFACE_SELECT_FIELD == scs_pkg::SEL_EXTERNAL);
    // R7: per-interface sync enable
    sync_on = sel_int ? I_PROTOCOL_CONFIG_REG[scs_pkg::PROTO_INT_SYNC_BIT]
            : sel_ext ? I_PROTOCOL_CONFIG_REG[scs_pkg::PROTO_EXT_SYNC_BIT] : 1'b0;
    // R21: sync-only features
    nine   = sync_on && I_PROTOCOL_CONFIG_REG[scs_pkg::PROTO_NINE_BIT_BIT];
    direct = sync_on && I_TRANSMIT_CONTROL_REG[scs_pkg::TXCTL_DIRECT_BIT];
    stop    = sel_int ? I_INTERNAL_CLOCK_STOP : I_EXTERNAL_CLOCK_STOP;
    lvl     = sel_int ? I_INTERNAL_CLOCK_STOP_LEVEL : I_EXTERNAL_CLOCK_STOP_LEVEL;
    line_in = sel_int ? st_r.int_s2 : st_r.ext_s2;
    // R12: zero length disables counting
    counting = (st_r.len != scs_pkg::LEN_DISABLED);
    halted   = counting && st_r.done;
    half     = (I_ETU_HALF_PERIOD == '0) ? DIV_W'(1) : I_ETU_HALF_PERIOD;
    last_ptr = nine ? 4'(scs_pkg::NINE_LAST_BIT) : 4'(scs_pkg::BYTE_LAST_BIT);
    st_nxt.stop_d = stop;
    // R3: card clock from the divider
    if (!sync_on) begin
      st_nxt.sclk = 1'b0;
      st_nxt.div  = half - 1'b1;
    end else if (st_r.stop_d && !stop) begin
      // R10: restart from stop
      st_nxt.div = half - 1'b1;
      if (st_r.sclk) begin
        st_nxt.sclk = 1'b0;
        fall = 1'b1;
        // R15: no FIFO clock on this fall while the count is still zero
        skip = counting && (st_r.cnt == '0) && !st_r.done;
      end
    end else if (st_r.div == '0) begin
      st_nxt.div = half - 1'b1;
      // R9: stop only at a phase end; R14: halted holds the clock unless a stop moves it to the stop level
      if (stop ? (st_r.sclk != lvl)
               : !(halted || (!I_TX_MODE && counting && !rx_f_ready))) begin
        st_nxt.sclk = ~st_r.sclk;
        rise = ~st_r.sclk;
        fall = st_r.sclk;
      end
    end else begin
      st_nxt.div = st_r.div - 1'b1;
    end
    engine = counting && !st_r.done && !skip;
    // R6: launch on fall
    if (fall && engine) begin
      // R11: count falling edges
      st_nxt.cnt = st_r.cnt + scs_pkg::CNT_STEP;
      // R13: reached loaded value
      if (st_nxt.cnt == st_r.len) begin
        st_nxt.done = 1'b1;
        set_flag = 1'b1;
      end
      if (I_TX_MODE) begin
        if (st_r.ptr == scs_pkg::PTR_FIRST) begin
          if (tx_f_valid) begin
            tx_f_ready_out = 1'b1;
            st_nxt.sh_tx = tx_f_data;
            st_nxt.tx_bit = tx_f_data[0];
          end
        end else begin
          st_nxt.tx_bit = st_r.sh_tx[st_r.ptr[2:0]];
        end
        st_nxt.ptr = (st_r.ptr == 4'(scs_pkg::BYTE_LAST_BIT)) ? scs_pkg::PTR_FIRST
                   : st_r.ptr + scs_pkg::PTR_STEP;
      end
    end
    // R6: sample on rise
    if (rise) begin
      // R16: line level captured
      if (sel_int) st_nxt.int_samp = line_in;
      else if (sel_ext) st_nxt.ext_samp = line_in;
      if (!I_TX_MODE && counting && !st_r.done) begin
        rx_word[st_r.ptr] = line_in;
        st_nxt.sh_rx = rx_word;
        if (st_r.ptr == last_ptr) begin
          // R18: ninth bit kept, available on its capture
          rx_word[scs_pkg::NINE_LAST_BIT] = nine && rx_word[scs_pkg::NINE_LAST_BIT];
          rx_push = 1'b1;
          st_nxt.rx_dav = 1'b1;
          st_nxt.ptr = scs_pkg::PTR_FIRST;
        end else begin
          st_nxt.ptr = st_r.ptr + scs_pkg::PTR_STEP;
        end
      end
    end
    // R20: direction change resets pointer
    st_nxt.tx_mode_d = I_TX_MODE;
    if (I_TX_MODE != st_r.tx_mode_d) st_nxt.ptr = scs_pkg::PTR_FIRST;
    // R25: load restarts the counter
    if (I_BIT_LENGTH_LOAD) begin
      st_nxt.len  = I_BIT_LENGTH_VALUE;
      st_nxt.cnt  = '0;
      st_nxt.done = 1'b0;
    end
    // R13: set wins over clear
    st_nxt.flag = set_flag || (st_r.flag && !I_IRQ_CLEAR);
    st_nxt.irq  = st_nxt.flag && I_CARD_IRQ_ENABLE_REG[scs_pkg::IRQ_BIT_LEN_BIT];
    // R12: R17: R24: engine owns line only while counting
    engine = sync_on && !I_BYPASS_ENABLE && counting && !(st_r.done && direct);
    st_nxt.int_io = I_INTERNAL_LINE_DATA;
    st_nxt.int_oe = I_INTERNAL_LINE_DIR;
    st_nxt.ext_io = I_EXTERNAL_LINE_DATA;
    st_nxt.ext_oe = I_EXTERNAL_LINE_DIR;
    if (engine && sel_int) begin
      st_nxt.int_io = I_TX_MODE ? st_nxt.tx_bit : 1'b1;
      st_nxt.int_oe = I_TX_MODE;
    end else if (engine && sel_ext) begin
      st_nxt.ext_io = I_TX_MODE ? st_nxt.tx_bit : 1'b1;
      st_nxt.ext_oe = I_TX_MODE;
    end
    // R5: sync clock only on the selected interface
    st_nxt.int_clk = I_PROTOCOL_CONFIG_REG[scs_pkg::PROTO_INT_SYNC_BIT] ? (sel_int && st_nxt.sclk)
                   : I_INTERNAL_ASYNC_CLOCK;
    st_nxt.ext_clk = I_PROTOCOL_CONFIG_REG[scs_pkg::PROTO_EXT_SYNC_BIT] ? (sel_ext && st_nxt.sclk)
                   : I_EXTERNAL_ASYNC_CLOCK;
    // R22: reset follows firmware bit in sync mode
    st_nxt.card_rst = sync_on ? I_CARD_RESET_BIT : I_SEQUENCER_CARD_RESET;
    st_nxt.int_s1 = I_INTERNAL_IO;
    st_nxt.int_s2 = st_r.int_s1;
    st_nxt.ext_s1 = I_EXTERNAL_CARD_LINE;
    st_nxt.ext_s2 = st_r.ext_s1;
    // Output stage keeps read data on a flop
    rx_pop = rx_f_valid && (!st_r.rx_vld || I_RX_READY);
    if (rx_pop) begin
      st_nxt.rx_out = rx_f_data;
      st_nxt.rx_vld = 1'b1;
    end else if (I_RX_READY) begin
      st_nxt.rx_vld = 1'b0;
    end
    // R19: second transmit read flushes
    tx_flush = I_TX_FIFO_READ && st_r.rd_once;
    if (I_TX_VALID) st_nxt.rd_once = 1'b0;
    else if (I_TX_FIFO_READ) st_nxt.rd_once = !st_r.rd_once;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      st_r <= '0;
      st_r.int_io <= 1'b1;
      st_r.ext_io <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_RX_DATA                = st_r.rx_out;
  assign O_RX_VALID               = st_r.rx_vld;
  assign O_INTERNAL_IO            = st_r.int_io;
  assign O_INTERNAL_IO_OE         = st_r.int_oe;
  assign O_EXTERNAL_CARD_LINE     = st_r.ext_io;
  assign O_EXTERNAL_CARD_LINE_OE  = st_r.ext_oe;
  assign O_INTERNAL_CARD_CLOCK    = st_r.int_clk;
  assign O_EXTERNAL_CARD_CLOCK    = st_r.ext_clk;
  assign O_CARD_RESET             = st_r.card_rst;
  assign O_INTERNAL_LINE_SAMPLE   = st_r.int_samp;
  assign O_EXTERNAL_LINE_SAMPLE   = st_r.ext_samp;
  assign O_BIT_LENGTH_IRQ_FLAG    = st_r.flag;
  assign O_IRQ                    = st_r.irq;
  assign O_RECEIVE_DATA_AVAILABLE = st_r.rx_dav;
  assign O_BIT_COUNT              = st_r.cnt;
endmodule : scs_sync

// File: test/scs_sync_asserts.sv
`timescale 1ns/1ns
module scs_sync_chk (
  input wire logic       I_CLOCK,
  input wire logic       I_SRST,
  input wire logic [1:0] I_INTERFACE_SELECT_FIELD,
  input wire logic       I_BYPASS_ENABLE,
  input wire logic [7:0] I_PROTOCOL_CONFIG_REG,
  input wire logic [7:0] I_CARD_IRQ_ENABLE_REG,
  input wire logic       I_INTERNAL_CLOCK_STOP,
  input wire logic       I_INTERNAL_CLOCK_STOP_LEVEL,
  input wire logic       I_BIT_LENGTH_LOAD,
  input wire logic [7:0] I_BIT_LENGTH_VALUE,
  input wire logic       I_IRQ_CLEAR,
  input wire logic       I_INTERNAL_LINE_DIR,
  input wire logic       I_CARD_RESET_BIT,
  input wire logic       O_INTERNAL_IO_OE,
  input wire logic       O_INTERNAL_CARD_CLOCK,
  input wire logic       O_EXTERNAL_CARD_CLOCK,
  input wire logic       O_CARD_RESET,
  input wire logic       O_BIT_LENGTH_IRQ_FLAG,
  input wire logic       O_IRQ,
  input wire logic       O_RX_VALID,
  input wire logic [7:0] O_BIT_COUNT
);
  logic [7:0] len_r;
  logic       int_sync;
  logic       int_off;
  logic       ext_off;
  always_ff @(posedge I_CLOCK)
    if (I_SRST) len_r <= 8'h00;
    else if (I_BIT_LENGTH_LOAD) len_r <= I_BIT_LENGTH_VALUE;
  assign int_sync = I_PROTOCOL_CONFIG_REG[7] && I_INTERFACE_SELECT_FIELD[1];
  assign int_off  = I_PROTOCOL_CONFIG_REG[7] && !I_INTERFACE_SELECT_FIELD[1];
  assign ext_off  = I_PROTOCOL_CONFIG_REG[5] && I_INTERFACE_SELECT_FIELD != 2'h1;
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SRST);
  // Irq is the registered flag gated by the enable of the cycle before, so a clear never trips it
  a_irq_follows_flag: assert property (1'b1 |=> O_IRQ == (O_BIT_LENGTH_IRQ_FLAG && $past(I_CARD_IRQ_ENABLE_REG[7])))
    else $error("irq not following flag");
  a_irq_masked: assert property (!I_CARD_IRQ_ENABLE_REG[7] |=> !O_IRQ)
    else $error("masked irq raised");
  a_flag_sticky: assert property (O_BIT_LENGTH_IRQ_FLAG && !I_IRQ_CLEAR |=> O_BIT_LENGTH_IRQ_FLAG)
    else $error("flag dropped");
  a_load_clears: assert property (I_BIT_LENGTH_LOAD |=> O_BIT_COUNT == 8'h00)
    else $error("load kept count");
  a_count_step: assert property ($changed(O_BIT_COUNT) && !$past(I_BIT_LENGTH_LOAD) |->
    O_BIT_COUNT == $past(O_BIT_COUNT) + 8'h01) else $error("count jumped");
  a_zero_idle: assert property (len_r == 8'h00 |=> $stable(O_BIT_COUNT))
    else $error("count moved at zero length");
  a_count_halt: assert property (len_r != 8'h00 |-> O_BIT_COUNT <= len_r)
    else $error("count passed length");
  a_flag_on_max: assert property (len_r != 8'h00 && $changed(O_BIT_COUNT) && O_BIT_COUNT == len_r
    |-> ##[0:2] O_BIT_LENGTH_IRQ_FLAG) else $error("no flag at length");
  a_int_unselected: assert property (int_off && $past(int_off) && $past(int_off, 2) |-> !O_INTERNAL_CARD_CLOCK)
    else $error("unselected internal clock runs");
  a_ext_unselected: assert property (ext_off && $past(ext_off) && $past(ext_off, 2) |-> !O_EXTERNAL_CARD_CLOCK)
    else $error("unselected external clock runs");
  a_stop_holds: assert property (int_sync && I_INTERNAL_CLOCK_STOP && $past(I_INTERNAL_CLOCK_STOP, 3)
    && $stable(I_INTERNAL_CLOCK_STOP_LEVEL) && O_INTERNAL_CARD_CLOCK == I_INTERNAL_CLOCK_STOP_LEVEL
    |=> $stable(O_INTERNAL_CARD_CLOCK)) else $error("stopped clock moved");
  a_reset_follows: assert property (int_sync && $past(int_sync) && !$past(I_SRST)
    |-> O_CARD_RESET == $past(I_CARD_RESET_BIT)) else $error("card reset not following");
  a_bypass_dir: assert property ($past(I_BYPASS_ENABLE) && !$past(I_SRST)
    |-> O_INTERNAL_IO_OE == $past(I_INTERNAL_LINE_DIR)) else $error("bypass drive wrong");
  c_done: cover property (O_BIT_COUNT == 8'h08 && O_BIT_LENGTH_IRQ_FLAG);
  c_rx: cover property (O_RX_VALID);
  c_irq: cover property (O_IRQ);
  c_bypass: cover property (I_BYPASS_ENABLE && O_INTERNAL_IO_OE);
endmodule : scs_sync_chk
bind scs_sync scs_sync_chk u_scs_sync_chk (.I_CLOCK, .I_SRST, .I_INTERFACE_SELECT_FIELD, .I_BYPASS_ENABLE,
  .I_PROTOCOL_CONFIG_REG, .I_CARD_IRQ_ENABLE_REG, .I_INTERNAL_CLOCK_STOP, .I_INTERNAL_CLOCK_STOP_LEVEL,
  .I_BIT_LENGTH_LOAD, .I_BIT_LENGTH_VALUE, .I_IRQ_CLEAR, .I_INTERNAL_LINE_DIR, .I_CARD_RESET_BIT,
  .O_INTERNAL_IO_OE, .O_INTERNAL_CARD_CLOCK, .O_EXTERNAL_CARD_CLOCK, .O_CARD_RESET, .O_BIT_LENGTH_IRQ_FLAG,
  .O_IRQ, .O_RX_VALID, .O_BIT_COUNT);

// File: test/scs_card.sv
`timescale 1ns/1ns
module scs_card (
  input  wire logic       i_clk,
  input  wire logic       i_talk,
  input  wire logic [7:0] i_byte,
  output logic            o_line,
  output logic            o_oe
);
  logic [2:0] k;
  assign o_oe = i_talk;
  always @(posedge i_talk) begin
    o_line = i_byte[0];
    k = 3'h1;
  end
  always @(negedge i_clk) begin
    if (i_talk) begin
      o_line <= i_byte[k];
      k <= k + 3'h1;
    end
  end
endmodule : scs_card

// File: test/tb_scs_sync.sv
`timescale 1ns/1ns
module tb_scs_sync;
  logic I_CLOCK, I_SRST, I_BYPASS_ENABLE, I_INTERNAL_CLOCK_STOP, I_INTERNAL_CLOCK_STOP_LEVEL, I_EXTERNAL_CLOCK_STOP;
  logic I_EXTERNAL_CLOCK_STOP_LEVEL, I_INTERNAL_ASYNC_CLOCK, I_EXTERNAL_ASYNC_CLOCK, I_BIT_LENGTH_LOAD, I_IRQ_CLEAR;
  logic I_TX_MODE, I_INTERNAL_LINE_DATA, I_INTERNAL_LINE_DIR, I_EXTERNAL_LINE_DATA, I_EXTERNAL_LINE_DIR;
  logic I_CARD_RESET_BIT, I_SEQUENCER_CARD_RESET, I_TX_VALID, I_TX_FIFO_READ, I_RX_READY, ext_drv, card_talk, watch;
  logic [1:0] I_INTERFACE_SELECT_FIELD;
  logic [7:0] I_PROTOCOL_CONFIG_REG, I_TRANSMIT_CONTROL_REG, I_CARD_IRQ_ENABLE_REG, I_ETU_HALF_PERIOD;
  logic [7:0] I_BIT_LENGTH_VALUE, I_TX_DATA, card_byte, cnt_q, b;
  wire O_TX_READY, O_RX_VALID, O_INTERNAL_IO, O_INTERNAL_IO_OE, O_EXTERNAL_CARD_LINE, O_EXTERNAL_CARD_LINE_OE;
  wire O_INTERNAL_CARD_CLOCK, O_EXTERNAL_CARD_CLOCK, O_CARD_RESET, O_INTERNAL_LINE_SAMPLE, O_EXTERNAL_LINE_SAMPLE;
  wire O_BIT_LENGTH_IRQ_FLAG, O_IRQ, O_RECEIVE_DATA_AVAILABLE, card_line, card_oe;
  wire [8:0] O_RX_DATA;
  wire [7:0] O_BIT_COUNT;
  // Card line has a pull-up when nobody drives
  wire I_INTERNAL_IO = O_INTERNAL_IO_OE ? O_INTERNAL_IO : card_oe ? card_line : 1'b1;
  wire I_EXTERNAL_CARD_LINE = O_EXTERNAL_CARD_LINE_OE ? O_EXTERNAL_CARD_LINE : ext_drv;
  logic [8:0] expq[$];
  logic [31:0] seed;
  int err_total, n_checks, dly, n_dav;
  scs_sync #(.DIV_W(8), .DEPTH(8)) u_scs_sync (.I_CLOCK, .I_SRST, .I_INTERFACE_SELECT_FIELD, .I_BYPASS_ENABLE,
    .I_PROTOCOL_CONFIG_REG, .I_TRANSMIT_CONTROL_REG, .I_CARD_IRQ_ENABLE_REG, .I_ETU_HALF_PERIOD,
    .I_INTERNAL_CLOCK_STOP, .I_INTERNAL_CLOCK_STOP_LEVEL, .I_EXTERNAL_CLOCK_STOP, .I_EXTERNAL_CLOCK_STOP_LEVEL,
    .I_INTERNAL_ASYNC_CLOCK, .I_EXTERNAL_ASYNC_CLOCK, .I_BIT_LENGTH_LOAD, .I_BIT_LENGTH_VALUE, .I_IRQ_CLEAR,
    .I_TX_MODE, .I_INTERNAL_LINE_DATA, .I_INTERNAL_LINE_DIR, .I_EXTERNAL_LINE_DATA, .I_EXTERNAL_LINE_DIR,
    .I_CARD_RESET_BIT, .I_SEQUENCER_CARD_RESET, .I_TX_DATA, .I_TX_VALID, .O_TX_READY, .I_TX_FIFO_READ,
    .O_RX_DATA, .O_RX_VALID, .I_RX_READY, .I_INTERNAL_IO, .O_INTERNAL_IO, .O_INTERNAL_IO_OE,
    .I_EXTERNAL_CARD_LINE, .O_EXTERNAL_CARD_LINE, .O_EXTERNAL_CARD_LINE_OE, .O_INTERNAL_CARD_CLOCK,
    .O_EXTERNAL_CARD_CLOCK, .O_CARD_RESET, .O_INTERNAL_LINE_SAMPLE, .O_EXTERNAL_LINE_SAMPLE,
    .O_BIT_LENGTH_IRQ_FLAG, .O_IRQ, .O_RECEIVE_DATA_AVAILABLE, .O_BIT_COUNT);
  scs_card u_scs_card (.i_clk(O_INTERNAL_CARD_CLOCK), .i_talk(card_talk), .i_byte(card_byte),
    .o_line(card_line), .o_oe(card_oe));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [8:0] s, input logic [8:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge I_CLOCK);
  endtask : cyc
  task automatic load(input logic [7:0] v);
    I_IRQ_CLEAR = 1'b1;
    I_BIT_LENGTH_VALUE = v;
    I_BIT_LENGTH_LOAD = 1'b1;
    cyc(1);
    I_IRQ_CLEAR = 1'b0;
    I_BIT_LENGTH_LOAD = 1'b0;
  endtask : load
  task automatic wait_done(input logic [7:0] n);
    for (int i = 0; i < 400 && O_BIT_LENGTH_IRQ_FLAG !== 1'b1; i++) cyc(1);
    cyc(4);
    chk("bit_flag", {8'h00, O_BIT_LENGTH_IRQ_FLAG}, 9'h001);
    chk("bit_count", {1'b0, O_BIT_COUNT}, {1'b0, n});
  endtask : wait_done
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial begin
    I_CLOCK = 1'b0;
    forever #10 I_CLOCK = ~I_CLOCK;
  end
  // Results arrive here and meet the oldest note
  always @(posedge I_CLOCK) begin
    if (O_RX_VALID === 1'b1 && I_RX_READY) chk("rx_word", O_RX_DATA, expq.size() ? expq.pop_front() : 9'h1FF);
    if (O_RECEIVE_DATA_AVAILABLE === 1'b1) n_dav++;
    if (O_BIT_COUNT !== cnt_q) begin
      cnt_q = O_BIT_COUNT;
      dly = 3;
    end else if (dly > 0) begin
      dly--;
      if (dly == 0 && watch && cnt_q != 8'h00) chk("tx_bit", {8'h00, O_INTERNAL_IO}, expq.pop_front());
    end
  end
  initial begin
    #400000;
    err_total++;
    $display("MISMATCH watchdog exp done seen timeout");
    final_report();
  end
  initial begin
    seed = 32'h0000000C;
    {I_SRST, I_BYPASS_ENABLE, I_INTERNAL_CLOCK_STOP, I_INTERNAL_CLOCK_STOP_LEVEL, I_EXTERNAL_CLOCK_STOP,
     I_EXTERNAL_CLOCK_STOP_LEVEL, I_INTERNAL_ASYNC_CLOCK, I_EXTERNAL_ASYNC_CLOCK, I_BIT_LENGTH_LOAD, I_IRQ_CLEAR,
     I_TX_MODE, I_INTERNAL_LINE_DATA, I_INTERNAL_LINE_DIR, I_EXTERNAL_LINE_DATA, I_EXTERNAL_LINE_DIR,
     I_CARD_RESET_BIT, I_SEQUENCER_CARD_RESET, I_TX_VALID, I_TX_FIFO_READ, ext_drv, card_talk, watch} = '0;
    {I_INTERFACE_SELECT_FIELD, I_PROTOCOL_CONFIG_REG, I_TRANSMIT_CONTROL_REG, I_BIT_LENGTH_VALUE} = '0;
    {I_TX_DATA, card_byte, cnt_q, b, dly} = '0;
    I_ETU_HALF_PERIOD = 8'h04;
    I_CARD_IRQ_ENABLE_REG = 8'h80;
    I_RX_READY = 1'b1;
    I_SRST = 1'b1;
    cyc(4);
    // Line idles high only until the control bits take over after release
    chk("reset_out", {7'h00, O_TX_READY, O_INTERNAL_IO}, 9'h003);
    I_SRST = 1'b0;
    cyc(1);
    I_INTERFACE_SELECT_FIELD = 2'h2;
    I_PROTOCOL_CONFIG_REG = 8'h80;
    for (int i = 0; i < 8; i++) begin
      I_TX_DATA = 8'(rnd());
      I_TX_VALID = 1'b1;
      cyc(1);
    end
    I_TX_VALID = 1'b0;
    chk("tx_full", {8'h00, O_TX_READY}, 9'h000);
    // two reads flush the write side
    repeat (2) begin
      I_TX_FIFO_READ = 1'b1;
      cyc(1);
      I_TX_FIFO_READ = 1'b0;
      cyc(1);
    end
    chk("tx_flush", {8'h00, O_TX_READY}, 9'h001);
    b = 8'(rnd());
    I_TX_DATA = b;
    I_TX_VALID = 1'b1;
    cyc(1);
    I_TX_VALID = 1'b0;
    I_TX_MODE = 1'b1;
    for (int i = 0; i < 8; i++) expq.push_back({8'h00, b[i]});
    watch = 1'b1;
    load(8'h08);
    wait_done(8'h08);
    watch = 1'b0;
    chk("irq", {8'h00, O_IRQ}, 9'h001);
    // finished count hands line to control bits
    I_TRANSMIT_CONTROL_REG = 8'h80;
    I_INTERNAL_LINE_DIR = 1'b1;
    cyc(3);
    chk("direct", {7'h00, O_INTERNAL_IO_OE, O_INTERNAL_IO}, 9'h002);
    I_TRANSMIT_CONTROL_REG = 8'h00;
    I_INTERNAL_LINE_DIR = 1'b0;
    I_TX_MODE = 1'b0;
    // Receive fifo stalls while two words arrive
    I_RX_READY = 1'b0;
    repeat (2) begin
      card_byte = 8'(rnd());
      expq.push_back({1'b0, card_byte});
      card_talk = 1'b1;
      load(8'h08);
      wait_done(8'h08);
      card_talk = 1'b0;
      // Let the card see its talk line drop before the next word
      cyc(1);
    end
    chk("line_sample", {8'h00, O_INTERNAL_LINE_SAMPLE}, {8'h00, card_byte[7]});
    I_RX_READY = 1'b1;
    cyc(6);
    // nine-bit word, the card wraps back to its bit 0 on the ninth clock
    I_PROTOCOL_CONFIG_REG = 8'hC0;
    card_byte = 8'(rnd());
    expq.push_back({card_byte[0], card_byte});
    card_talk = 1'b1;
    load(8'h09);
    wait_done(8'h09);
    card_talk = 1'b0;
    I_PROTOCOL_CONFIG_REG = 8'h80;
    cyc(2);
    // clock parks high, restart fall is not counted
    I_INTERNAL_CLOCK_STOP_LEVEL = 1'b1;
    I_INTERNAL_CLOCK_STOP = 1'b1;
    load(8'h03);
    cyc(20);
    chk("stop_high", {O_INTERNAL_CARD_CLOCK, O_BIT_COUNT}, 9'h100);
    I_INTERNAL_CLOCK_STOP = 1'b0;
    cyc(2);
    chk("restart", {O_INTERNAL_CARD_CLOCK, O_BIT_COUNT}, 9'h000);
    wait_done(8'h03);
    // firmware pokes lines and modes at random
    for (int i = 0; i < 300; i++) begin
      b = 8'(rnd());
      {I_EXTERNAL_ASYNC_CLOCK, I_INTERNAL_ASYNC_CLOCK, I_SEQUENCER_CARD_RESET, I_EXTERNAL_CLOCK_STOP,
       I_EXTERNAL_CLOCK_STOP_LEVEL, I_EXTERNAL_LINE_DATA, I_EXTERNAL_LINE_DIR, I_CARD_RESET_BIT} = b;
      {ext_drv, I_BYPASS_ENABLE, I_INTERNAL_LINE_DATA, I_INTERNAL_LINE_DIR} = seed[11:8];
      I_INTERFACE_SELECT_FIELD = seed[13:12];
      I_PROTOCOL_CONFIG_REG = {seed[14], 1'b0, seed[15], 5'h00};
      I_CARD_IRQ_ENABLE_REG = {seed[16], 7'h00};
      cyc(1);
      // Flag is still set from the last count, so irq shows the enable alone
      chk("irq_mask", {8'h00, O_IRQ}, {8'h00, I_CARD_IRQ_ENABLE_REG[7]});
      if (I_BYPASS_ENABLE) chk("bypass_lines",
        {5'h00, O_EXTERNAL_CARD_LINE_OE, O_EXTERNAL_CARD_LINE, O_INTERNAL_IO_OE, O_INTERNAL_IO},
        {5'h00, I_EXTERNAL_LINE_DIR, I_EXTERNAL_LINE_DATA, I_INTERNAL_LINE_DIR, I_INTERNAL_LINE_DATA});
      if (I_PROTOCOL_CONFIG_REG[7:5] == 3'h0) chk("async_clk",
        {7'h00, O_INTERNAL_CARD_CLOCK, O_EXTERNAL_CARD_CLOCK}, {7'h00, I_INTERNAL_ASYNC_CLOCK, I_EXTERNAL_ASYNC_CLOCK});
    end
    chk("pending", 9'(expq.size()), 9'h000);
    chk("dav_count", 9'(n_dav), 9'h003);
    final_report();
  end
endmodule : tb_scs_sync
